/* File: hw/dmif_crc_tail.sv */
// delays the cipher core completion by the crc write-back cycles
// assumes done is a one-cycle pulse synchronous to aclk
`timescale 1ns/1ns
module dmif_crc_tail (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic done_in,
    output logic      done_out
);
    localparam int N = dmif_pkg::CRC_CYCLES;

    logic [N-1:0] stage_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage_reg <= '0;
        end else begin
            stage_reg <= {stage_reg[N-2:0], done_in};
        end
    end

    assign done_out = stage_reg[N-1];
endmodule : dmif_crc_tail

/* File: hw/dmif_top.sv */
// datapath interrupt flag and enable register with AXI4-Lite slave
// assumes event inputs are one-cycle pulses synchronous to aclk
//
// Summary of operation
// R01 - every reset clears control register to zero
// R02 - firmware may read and write register freely
// R03 - phy transmit done sets sticky bit 0
// R04 - phy receive decode done sets bit 2
// R05 - frame moved into buffer sets bit 3
// R06 - cipher done plus two crc cycles sets bit 4
// R07 - carrier detect sets sticky bit 5
// R08 - valid frame detect sets sticky bit 6
// R09 - firmware must clear each flag after service
// R10 - enable bits 8..15 gate each interrupt
// R11 - overrun enabled: set bit 7, flush frame
// R12 - event beats same-cycle software clear
`timescale 1ns/1ns
module dmif_top (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        ev_phy_tx_done,
    input  wire logic        ev_buf_tx_done,
    input  wire logic        ev_phy_rx_done,
    input  wire logic        ev_buf_rx_done,
    input  wire logic        cipher_op_done,
    input  wire logic        ev_carrier_sense,
    input  wire logic        ev_frame_detect,
    input  wire logic        frame_rx_start,
    input  wire logic        fec_data_pending,
    output logic             irq,
    output logic             fec_flush
);
    logic [15:0] ctrl_reg;
    logic [15:0] ctrl_base;
    logic [15:0] ctrl_next;
    logic [7:0]  ev_vec;
    logic        cipher_tail;
    logic        ovr_event;
    logic        awready_reg;
    logic        wready_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        arready_reg;
    logic        rvalid_reg;
    logic [1:0]  rresp_reg;
    logic [31:0] rdata_reg;
    logic        irq_reg;
    logic        fec_flush_reg;
    logic        wr_fire;
    logic        rd_fire;
    logic        wr_ctrl;
    logic        wr_fclr;
    logic [5:0]  wr_idx;
    logic [5:0]  rd_idx;

    dmif_crc_tail u_crc_tail (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .done_in  (cipher_op_done),
        .done_out (cipher_tail)
    );

    // overrun: new frame while fec data still pending
    assign ovr_event = ctrl_reg[dmif_pkg::BIT_OVR_EN] & frame_rx_start
                     & fec_data_pending; // [R11]

    assign ev_vec[dmif_pkg::BIT_PHY_TX]  = ev_phy_tx_done;   // [R03]
    assign ev_vec[dmif_pkg::BIT_BUF_TX]  = ev_buf_tx_done;
    assign ev_vec[dmif_pkg::BIT_PHY_RX]  = ev_phy_rx_done;   // [R04]
    assign ev_vec[dmif_pkg::BIT_BUF_RX]  = ev_buf_rx_done;   // [R05]
    assign ev_vec[dmif_pkg::BIT_CIPHER]  = cipher_tail;      // [R06]
    assign ev_vec[dmif_pkg::BIT_CARRIER] = ev_carrier_sense; // [R07]
    assign ev_vec[dmif_pkg::BIT_FRAME]   = ev_frame_detect;  // [R08]
    assign ev_vec[dmif_pkg::BIT_OVR]     = ovr_event;        // [R11]

    // write decode, both channels taken in the same cycle
    assign wr_fire = s_axi_awvalid & s_axi_wvalid & awready_reg & wready_reg;
    assign rd_fire = s_axi_arvalid & arready_reg;
    assign wr_idx  = s_axi_awaddr[7:2];
    assign rd_idx  = s_axi_araddr[7:2];
    assign wr_ctrl = wr_fire & (wr_idx == dmif_pkg::CTRL_IDX);
    assign wr_fclr = wr_fire & (wr_idx == dmif_pkg::FCLR_IDX);

    // software view: plain store or write-one-to-clear alias
    always_comb begin
        ctrl_base = ctrl_reg;
        if (wr_ctrl) begin // [R02]
            if (s_axi_wstrb[0]) begin
                ctrl_base[7:0] = s_axi_wdata[7:0];
            end
            if (s_axi_wstrb[1]) begin
                ctrl_base[15:8] = s_axi_wdata[15:8];
            end
        end else if (wr_fclr && s_axi_wstrb[0]) begin
            ctrl_base[7:0] = ctrl_reg[7:0] & ~s_axi_wdata[7:0];
        end
    end

    // sticky flags, hardware set wins over software clear
    genvar gi;
    generate
        for (gi = 0; gi < dmif_pkg::NUM_FLAGS; gi++) begin : g_flag
            assign ctrl_next[gi] = ctrl_base[gi] | ev_vec[gi]; // [R12]
        end
    endgenerate
    assign ctrl_next[15:8] = ctrl_base[15:8];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= dmif_pkg::CTRL_RESET; // [R01]
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // interrupt line and flush pulse
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_reg       <= 1'b0;
            fec_flush_reg <= 1'b0;
        end else begin
            irq_reg       <= |(ctrl_reg[7:0] & ctrl_reg[15:8]); // [R10]
            fec_flush_reg <= ovr_event; // [R11]
        end
    end

    // write address, data and response channels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_reg <= 1'b0;
            wready_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= dmif_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            awready_reg <= 1'b0;
            wready_reg  <= 1'b0;
            bvalid_reg  <= 1'b1;
            bresp_reg   <= (wr_ctrl | wr_fclr) ? dmif_pkg::RESP_OKAY
                                               : dmif_pkg::RESP_SLVERR;
        end else begin
            if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
            if (s_axi_awvalid && s_axi_wvalid && !awready_reg && !bvalid_reg) begin
                awready_reg <= 1'b1;
                wready_reg  <= 1'b1;
            end
        end
    end

    // read address and data channels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b0;
            rresp_reg   <= dmif_pkg::RESP_OKAY;
            rdata_reg   <= 32'h0000_0000;
        end else if (rd_fire) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b1;
            if (rd_idx == dmif_pkg::CTRL_IDX) begin
                rdata_reg <= {16'h0000, ctrl_reg};
                rresp_reg <= dmif_pkg::RESP_OKAY;
            end else if (rd_idx == dmif_pkg::FCLR_IDX) begin
                rdata_reg <= {24'h00_0000, ctrl_reg[7:0]};
                rresp_reg <= dmif_pkg::RESP_OKAY;
            end else begin
                rdata_reg <= 32'h0000_0000;
                rresp_reg <= dmif_pkg::RESP_SLVERR;
            end
        end else begin
            if (rvalid_reg && s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
            if (s_axi_arvalid && !arready_reg && !rvalid_reg) begin
                arready_reg <= 1'b1;
            end
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready  = wready_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rresp   = rresp_reg;
    assign s_axi_rdata   = rdata_reg;
    assign irq           = irq_reg;
    assign fec_flush     = fec_flush_reg;

    // checks
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    property p_reset_clear;
        disable iff (1'b0)
        !aresetn |=> (ctrl_reg == 16'h0000) && !irq && !s_axi_bvalid && !s_axi_rvalid;
    endproperty
    a_reset_clear: assert property (p_reset_clear) // [R01]
        else $error("control register not cleared by reset");

    property p_enable_write;
        wr_ctrl && (s_axi_wstrb[1:0] == 2'h3)
        |=> ctrl_reg[15:8] == $past(s_axi_wdata[15:8]);
    endproperty
    a_enable_write: assert property (p_enable_write) // [R02]
        else $error("enable byte not stored by write");

    property p_read_back;
        rd_fire && (rd_idx == dmif_pkg::CTRL_IDX)
        |=> s_axi_rvalid && (s_axi_rdata == {16'h0000, $past(ctrl_reg)});
    endproperty
    a_read_back: assert property (p_read_back) // [R02]
        else $error("read data does not match register");

    property p_phy_tx;
        ev_phy_tx_done |=> ctrl_reg[0];
    endproperty
    a_phy_tx: assert property (p_phy_tx) // [R03]
        else $error("phy transmit flag not set");

    property p_phy_rx;
        ev_phy_rx_done |=> ctrl_reg[2];
    endproperty
    a_phy_rx: assert property (p_phy_rx) // [R04]
        else $error("phy receive flag not set");

    property p_buf_rx;
        ev_buf_rx_done |=> ctrl_reg[3];
    endproperty
    a_buf_rx: assert property (p_buf_rx) // [R05]
        else $error("buffer receive flag not set");

    property p_cipher_delay;
        cipher_op_done |-> ##3 ctrl_reg[4];
    endproperty
    a_cipher_delay: assert property (p_cipher_delay) // [R06]
        else $error("cipher flag not set three cycles after done");

    property p_cipher_early;
        $rose(ctrl_reg[4]) && !$past(wr_fire) |-> $past(cipher_op_done, 3);
    endproperty
    a_cipher_early: assert property (p_cipher_early) // [R06]
        else $error("cipher flag set before crc write-back");

    property p_carrier;
        ev_carrier_sense |=> ctrl_reg[5];
    endproperty
    a_carrier: assert property (p_carrier) // [R07]
        else $error("carrier sense flag not set");

    property p_frame;
        ev_frame_detect |=> ctrl_reg[6];
    endproperty
    a_frame: assert property (p_frame) // [R08]
        else $error("frame detect flag not set");

    property p_irq_gate;
        ##1 irq == $past(|(ctrl_reg[7:0] & ctrl_reg[15:8]));
    endproperty
    a_irq_gate: assert property (p_irq_gate) // [R10]
        else $error("interrupt does not follow flags and enables");

    property p_overrun;
        frame_rx_start && fec_data_pending && ctrl_reg[15] |=> ctrl_reg[7] && fec_flush;
    endproperty
    a_overrun: assert property (p_overrun) // [R11]
        else $error("overrun not flagged or frame not flushed");

    property p_no_flush;
        !ctrl_reg[15] |=> !fec_flush;
    endproperty
    a_no_flush: assert property (p_no_flush) // [R11]
        else $error("flush without overrun detection enabled");

    property p_set_wins;
        wr_fclr && s_axi_wstrb[0] && s_axi_wdata[0] && ev_phy_tx_done |=> ctrl_reg[0];
    endproperty
    a_set_wins: assert property (p_set_wins) // [R12]
        else $error("event lost against same-cycle clear");

    // flags only fall through a software write
    property p_flags_sticky;
        !wr_ctrl && !wr_fclr
        |=> (ctrl_reg[7:0] & $past(ctrl_reg[7:0])) == $past(ctrl_reg[7:0]);
    endproperty
    a_flags_sticky: assert property (p_flags_sticky) // [R03]
        else $error("event flag dropped without software clear");

    property p_enables_hold;
        !wr_ctrl |=> ctrl_reg[15:8] == $past(ctrl_reg[15:8]);
    endproperty
    a_enables_hold: assert property (p_enables_hold) // [R10]
        else $error("enable byte changed without a write");

    property p_fclr;
        wr_fclr && s_axi_wstrb[0] && !(|ev_vec)
        |=> (ctrl_reg[7:0] & $past(s_axi_wdata[7:0])) == 8'h00;
    endproperty
    a_fclr: assert property (p_fclr) // [R02]
        else $error("write-one-to-clear left a flag set");

    property p_unmapped;
        wr_fire && !wr_ctrl && !wr_fclr
        |=> s_axi_bvalid && (s_axi_bresp == dmif_pkg::RESP_SLVERR);
    endproperty
    a_unmapped: assert property (p_unmapped) // [R02]
        else $error("unmapped write not answered with slave error");

    property p_bvalid_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bvalid_hold: assert property (p_bvalid_hold) // [R02]
        else $error("write response dropped before bready");

    property p_rvalid_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rvalid_hold: assert property (p_rvalid_hold) // [R02]
        else $error("read data dropped or changed before rready");

    property p_no_aw_busy;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_no_aw_busy: assert property (p_no_aw_busy) // [R02]
        else $error("write accepted while response still pending");

    c_write:    cover property (wr_ctrl ##[1:4] s_axi_bvalid && s_axi_bready);
    c_read:     cover property (rd_fire ##1 s_axi_rvalid && s_axi_rready);
    c_irq:      cover property ($rose(irq));
    c_overrun:  cover property (fec_flush);
    c_cipher:   cover property (cipher_op_done ##3 ctrl_reg[4]);
endmodule : dmif_top

/* File: inc/dmif_pkg.sv */
// constants for the datapath interrupt flag block
// assumes a 32-bit AXI4-Lite register bus, one word per register
package dmif_pkg;
    localparam int          ADDR_W      = 8;
    localparam int          DATA_W      = 32;
    localparam int          REG_W       = 16;
    localparam int          NUM_FLAGS   = 8;
    // register indices; byte address is four times the index
    localparam logic [5:0]  CTRL_IDX    = 6'h02;
    localparam logic [5:0]  FCLR_IDX    = 6'h03;
    localparam logic [15:0] CTRL_RESET  = 16'h0000;
    // flag bit positions
    localparam int          BIT_PHY_TX  = 0;
    localparam int          BIT_BUF_TX  = 1;
    localparam int          BIT_PHY_RX  = 2;
    localparam int          BIT_BUF_RX  = 3;
    localparam int          BIT_CIPHER  = 4;
    localparam int          BIT_CARRIER = 5;
    localparam int          BIT_FRAME   = 6;
    localparam int          BIT_OVR     = 7;
    // enable byte and overrun detection enable
    localparam int          EN_LSB      = 8;
    localparam int          BIT_OVR_EN  = 15;
    // cycles spent moving the crc32 result into buffer memory
    localparam int          CRC_CYCLES  = 2;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage : dmif_pkg

/* File: testbench/tb.sv */
// self-checking bench for the datapath interrupt flag block
// assumes dmif_top as the only design unit, driven over AXI4-Lite
`timescale 1ns/1ns
module tb;
    logic        aclk        = 1'b0;
    logic        aresetn     = 1'b0;
    logic [7:0]  awaddr      = 8'h00;
    logic        awvalid     = 1'b0;
    logic [31:0] wdata       = 32'h0000_0000;
    logic [3:0]  wstrb       = 4'h0;
    logic        wvalid      = 1'b0;
    logic        bready      = 1'b0;
    logic [7:0]  araddr      = 8'h00;
    logic        arvalid     = 1'b0;
    logic        rready      = 1'b0;
    logic [6:0]  ev          = 7'h00;
    logic        frame_start = 1'b0;
    logic        fec_pend    = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] s_axi_rdata, rd_data;
    logic        irq, fec_flush;
    int          num_errors  = 0;
    int          cmp_count   = 0;
    int          flushes;
    logic [31:0] ovr_en [3]  = '{32'h0000_8000, 32'h0000_0000, 32'h0000_8000};
    logic        ovr_pd [3]  = '{1'b1, 1'b1, 1'b0};

    always #25 aclk = ~aclk;

    dmif_top i_dmif_top (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(rready),
        .ev_phy_tx_done(ev[0]), .ev_buf_tx_done(ev[1]), .ev_phy_rx_done(ev[2]),
        .ev_buf_rx_done(ev[3]), .cipher_op_done(ev[4]), .ev_carrier_sense(ev[5]),
        .ev_frame_detect(ev[6]), .frame_rx_start(frame_start),
        .fec_data_pending(fec_pend), .irq(irq), .fec_flush(fec_flush)
    );

    task summarize;
        if (num_errors == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : summarize

    task chk(input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : chk

    task guard(input int n);
        if (n >= 100) begin
            num_errors++;
            summarize();
        end
    endtask : guard

    // evs is presented so that it is sampled at the edge that takes the write
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
            input logic [6:0] evs);
        int n;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        @(posedge aclk);
        ev <= evs;
        n = 0;
        while (s_axi_awready !== 1'b1 && n < 100) begin
            @(posedge aclk);
            n++;
        end
        guard(n);
        awvalid <= 1'b0;
        wvalid  <= 1'b0;
        ev      <= 7'h00;
        bready  <= 1'b1;
        n = 0;
        while (s_axi_bvalid !== 1'b1 && n < 100) begin
            @(posedge aclk);
            n++;
        end
        guard(n);
        resp = s_axi_bresp;
        bready <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a);
        int n;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        n = 0;
        while (s_axi_arready !== 1'b1 && n < 100) begin
            @(posedge aclk);
            n++;
        end
        guard(n);
        arvalid <= 1'b0;
        rready  <= 1'b1;
        n = 0;
        while (s_axi_rvalid !== 1'b1 && n < 100) begin
            @(posedge aclk);
            n++;
        end
        guard(n);
        rd_data = s_axi_rdata;
        resp    = s_axi_rresp;
        rready <= 1'b0;
    endtask : rd

    // one-cycle event, then irq must rise exactly lat edges after it is sampled
    task pulse(input int i, input int lat);
        @(posedge aclk);
        ev <= 7'h01 << i;
        @(posedge aclk);
        ev <= 7'h00;
        repeat (lat - 1) @(posedge aclk);
        #1;
        chk(32'h0, 32'(irq));
        @(posedge aclk);
        #1;
        chk(32'h1, 32'(irq));
    endtask : pulse

    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h08);
        chk(32'h0, rd_data);
        chk(32'(dmif_pkg::RESP_OKAY), 32'(resp));
        chk(32'h0, 32'(irq));
        wr(8'h08, 32'h0000_5A3C, 4'h3, 7'h00);
        chk(32'(dmif_pkg::RESP_OKAY), 32'(resp));
        rd(8'h08);
        chk(32'h0000_5A3C, rd_data);
        wr(8'h08, 32'h0000_FFFF, 4'h2, 7'h00);
        rd(8'h0C);
        chk(32'h0000_003C, rd_data);
        wr(8'h10, 32'h0000_FFFF, 4'h3, 7'h00);
        chk(32'(dmif_pkg::RESP_SLVERR), 32'(resp));
        rd(8'h10);
        chk(32'(dmif_pkg::RESP_SLVERR), 32'(resp));
        chk(32'h0, rd_data);
        rd(8'h08);
        chk(32'h0000_FF3C, rd_data);
        for (int i = 0; i < 7; i++) begin
            wr(8'h08, 32'h1 << (dmif_pkg::EN_LSB + i), 4'h3, 7'h00);
            pulse(i, (i == dmif_pkg::BIT_CIPHER) ? 1 + dmif_pkg::CRC_CYCLES : 1);
            rd(8'h08);
            chk(32'h0000_0101 << i, rd_data);
            wr(8'h08, 32'h1 << i, 4'h3, 7'h00);
            @(posedge aclk);
            chk(32'h0, 32'(irq));
            wr(8'h0C, 32'h1 << i, 4'h1, 7'h00);
            rd(8'h08);
            chk(32'h0, rd_data);
        end
        wr(8'h08, 32'h0000_0020, 4'h3, 7'h00);
        wr(8'h0C, 32'h0000_0020, 4'h1, 7'h20);
        rd(8'h08);
        chk(32'h0000_0020, rd_data);
        wr(8'h08, 32'h0000_0000, 4'h3, 7'h40);
        rd(8'h08);
        chk(32'h0000_0040, rd_data);
        for (int k = 0; k < 3; k++) begin
            wr(8'h08, ovr_en[k], 4'h3, 7'h00);
            @(posedge aclk);
            fec_pend    <= ovr_pd[k];
            frame_start <= 1'b1;
            @(posedge aclk);
            frame_start <= 1'b0;
            flushes = 0;
            repeat (6) begin
                @(posedge aclk);
                flushes += int'(fec_flush === 1'b1);
            end
            fec_pend <= 1'b0;
            chk(32'(ovr_en[k][15] & ovr_pd[k]), 32'(flushes));
            chk(32'(ovr_en[k][15] & ovr_pd[k]), 32'(irq));
            rd(8'h08);
            chk(ovr_en[k] | ((ovr_en[k][15] & ovr_pd[k]) ? 32'h80 : 32'h0), rd_data);
        end
        // reset again in mid-run with a live interrupt
        wr(8'h08, 32'h0000_0101, 4'h3, 7'h00);
        @(posedge aclk);
        chk(32'h1, 32'(irq));
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        chk(32'h0, 32'(irq));
        rd(8'h08);
        chk(32'h0, rd_data);
        summarize();
    end
endmodule : tb
